// ==== inc/cct_pkg.sv ====
package cct_pkg;

  // ==========================================================
  // Bus geometry
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 32;

  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [15:0] IDX_CONTROL = 16'hFFB6;
  localparam logic [15:0] IDX_STATUS = 16'hFFB7;
  localparam logic [15:0] IDX_COUNT_HI = 16'hFFB8;
  localparam logic [15:0] IDX_COUNT_LO = 16'hFFB9;
  localparam logic [15:0] IDX_COMPARE_HI = 16'hFFBA;
  localparam logic [15:0] IDX_COMPARE_LO = 16'hFFBB;
  localparam logic [15:0] IDX_CLOCK_STOP = 16'hFFFA;
  localparam logic [15:0] IDX_IRQ = 16'hFFBC;

  // ==========================================================
  // Values after reset
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_COMPARE = 8'hFF;
  localparam logic [7:0] RST_CLOCK_STOP = 8'hFF;
  localparam logic [3:0] RST_IRQ = 4'h0;

  // ==========================================================
  // Field positions
  localparam int unsigned CTL_TOL_HI = 7;
  localparam int unsigned CTL_MODE8 = 6;
  localparam int unsigned CTL_CKS_HI = 4;
  localparam int unsigned CTL_TOL_LO = 3;
  localparam int unsigned CTL_CKS_LO = 0;
  localparam int unsigned STS_OVIE_HI = 5;
  localparam int unsigned STS_CCLR_HI = 4;
  localparam int unsigned STS_OVIE_LO = 1;
  localparam int unsigned STS_CCLR_LO = 0;
  // Flag index 0..3: lower match, lower ovf, upper match, upper ovf
  localparam int unsigned FLAG_POS [4] = '{2, 3, 6, 7};
  localparam int unsigned IRQ_REQ_HI = 0;
  localparam int unsigned IRQ_REQ_LO = 1;
  localparam int unsigned IRQ_EN_HI = 2;
  localparam int unsigned IRQ_EN_LO = 3;

  // ==========================================================
  // Clock select codes
  localparam logic [2:0] CKS_CASCADE = 3'h0;
  localparam logic [2:0] CKS_DIV32 = 3'h4;
  localparam logic [2:0] CKS_DIV16 = 3'h5;
  localparam logic [2:0] CKS_DIV4 = 3'h6;
  localparam logic [2:0] CKS_SUB4 = 3'h7;
  localparam int unsigned PRESCALE_W = 5;

endpackage : cct_pkg

// ==== rtl/cct_timer.sv ====
// Overview of operation
// - Upper and lower bytes cascade into 16 bits
// - Upper select top bit picks 8-bit mode
// - Sixteen-bit count uses lower clock select
// - Sixteen-bit accesses go through staging latch
// - Counters reset to zero
// - Compare registers reset to all ones
// - Sixteen-bit match clear needs upper clear bit
// - Sixteen-bit wrap sets upper overflow flag
// - Wrap with enable sets upper request
// - Eight-bit counters use own clock selects
// - Eight-bit match clear per counter bit
// - Eight-bit wrap sets flag, request with enable
// - Sixteen-bit match sets flag and request
// - Eight-bit match sets side flag, request
// - Sixteen-bit toggles drive upper pin only
// - Eight-bit mode drives both toggle pins
// - Upper level bit sets pin on write
// - Control register write-only, resets zero
// - Upper select: cascade, prohibited, four clocks
// - Lower select: event, prohibited, four clocks
// - Flags cleared by read one, write zero
`timescale 1ns/1ns
`default_nettype none

module cct_timer (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // APB slave
  input wire logic [cct_pkg::ADDR_W-1:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [cct_pkg::DATA_W-1:0] i_pwdata,
  output logic [cct_pkg::DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Pins
  input wire logic i_event_input_pin,
  input wire logic i_sub_clk,
  output logic o_upper_toggle_pin,
  output logic o_lower_toggle_pin,
  // Interrupt requests
  output logic o_upper_irq,
  output logic o_lower_irq
);

  // ==========================================================
  // Declarations
  logic [7:0] timer_control;
  logic [7:0] clock_stop;
  logic [3:0] flg;
  logic [3:0] seen;
  logic [3:0] flg_set;
  logic ovie_h;
  logic ovie_l;
  logic cclr_h;
  logic cclr_l;
  logic [7:0] cnt_h;
  logic [7:0] cnt_l;
  logic [7:0] cmp_h;
  logic [7:0] cmp_l;
  logic [7:0] temp;
  logic [7:0] next_cnt_h;
  logic [7:0] next_cnt_l;
  logic [15:0] inc16;
  logic irq_h_req;
  logic irq_l_req;
  logic irq_h_en;
  logic irq_l_en;
  logic tog_h;
  logic tog_l;
  logic eq_h_q;
  logic eq_l_q;
  logic eq16_q;
  logic ev_s1;
  logic ev_s2;
  logic ev_s3;
  logic sub_s1;
  logic sub_s2;
  logic sub_s3;
  logic [1:0] sub_cnt;
  logic [cct_pkg::PRESCALE_W-1:0] pre;
  logic ev_edge;
  logic sub_edge;
  logic tick_32;
  logic tick_16;
  logic tick_4;
  logic tick_w;
  logic tick_l;
  logic tick_h8;
  logic mode8;
  logic eq_h;
  logic eq_l;
  logic eq16;
  logic match_h;
  logic match_l;
  logic clr16;
  logic clr_h8;
  logic clr_l8;
  logic ovf_h_evt;
  logic ovf_l_evt;
  logic [7:0] wd;
  logic acc_wr;
  logic setup_rd;
  logic sel_ctl;
  logic sel_sts;
  logic sel_ch;
  logic sel_cl;
  logic sel_mh;
  logic sel_ml;
  logic sel_stop;
  logic sel_irq;
  logic hit;
  logic [7:0] rd_mux;
  logic [7:0] sts_view;

  // ==========================================================
  // Pin synchronisers and clock sources
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ev_s1 <= 1'b0;
      ev_s2 <= 1'b0;
      ev_s3 <= 1'b0;
      sub_s1 <= 1'b0;
      sub_s2 <= 1'b0;
      sub_s3 <= 1'b0;
    end else begin
      ev_s1 <= i_event_input_pin;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
      sub_s1 <= i_sub_clk;
      sub_s2 <= sub_s1;
      sub_s3 <= sub_s2;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pre <= '0;
      sub_cnt <= 2'h0;
    end else begin
      pre <= pre + {{(cct_pkg::PRESCALE_W-1){1'b0}}, 1'b1};
      if (sub_edge) begin
        sub_cnt <= sub_cnt + 2'h1;
      end
    end
  end

  assign ev_edge = ev_s2 & ~ev_s3;
  assign sub_edge = sub_s2 & ~sub_s3;
  assign tick_32 = &pre;
  assign tick_16 = &pre[3:0];
  assign tick_4 = &pre[1:0];
  assign tick_w = sub_edge & (&sub_cnt);

  // Prohibited codes give no count
  function automatic logic sel_tick(input logic [2:0] code,
                                    input logic zero_src,
                                    input logic t32, input logic t16,
                                    input logic t4, input logic tw);
    logic r;
    r = 1'b0;
    case (code)
      cct_pkg::CKS_CASCADE: r = zero_src;
      cct_pkg::CKS_DIV32: r = t32;
      cct_pkg::CKS_DIV16: r = t16;
      cct_pkg::CKS_DIV4: r = t4;
      cct_pkg::CKS_SUB4: r = tw;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : sel_tick

  assign mode8 = timer_control[cct_pkg::CTL_MODE8];
  assign tick_l = sel_tick(timer_control[2:0], ev_edge, tick_32,
                           tick_16, tick_4, tick_w);
  assign tick_h8 = mode8 & sel_tick(timer_control[6:4], 1'b0,
                                    tick_32, tick_16, tick_4, tick_w);

  // ==========================================================
  // Compare and count
  assign eq_h = cnt_h == cmp_h;
  assign eq_l = cnt_l == cmp_l;
  assign eq16 = eq_h & eq_l;
  assign match_h = mode8 ? (eq_h & ~eq_h_q) : (eq16 & ~eq16_q);
  assign match_l = mode8 & eq_l & ~eq_l_q;
  assign clr16 = ~mode8 & cclr_h & eq16 & tick_l;
  assign clr_h8 = cclr_h & eq_h & tick_h8;
  assign clr_l8 = cclr_l & eq_l & tick_l;
  assign inc16 = {cnt_h, cnt_l} + 16'h0001;
  assign ovf_h_evt = mode8 ? (tick_h8 & ~clr_h8 & (&cnt_h))
                           : (tick_l & ~clr16 & (&{cnt_h, cnt_l}));
  assign ovf_l_evt = mode8 & tick_l & ~clr_l8 & (&cnt_l);

  always_comb begin
    next_cnt_h = cnt_h;
    next_cnt_l = cnt_l;
    if (!mode8) begin
      if (clr16) begin
        next_cnt_h = 8'h00;
        next_cnt_l = 8'h00;
      end else if (tick_l) begin
        next_cnt_h = inc16[15:8];
        next_cnt_l = inc16[7:0];
      end
    end else begin
      if (clr_h8) begin
        next_cnt_h = 8'h00;
      end else if (tick_h8) begin
        next_cnt_h = cnt_h + 8'h01;
      end
      if (clr_l8) begin
        next_cnt_l = 8'h00;
      end else if (tick_l) begin
        next_cnt_l = cnt_l + 8'h01;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      eq_h_q <= 1'b0;
      eq_l_q <= 1'b0;
      eq16_q <= 1'b0;
    end else begin
      eq_h_q <= eq_h;
      eq_l_q <= eq_l;
      eq16_q <= eq16;
    end
  end

  // ==========================================================
  // APB decode
  assign wd = i_pwdata[7:0];
  assign acc_wr = i_psel & i_penable & i_pwrite & hit;
  // Unmapped reads still load, so they return zero
  assign setup_rd = i_psel & ~i_penable & ~i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~hit;

  always_comb begin
    sel_ctl = 1'b0;
    sel_sts = 1'b0;
    sel_ch = 1'b0;
    sel_cl = 1'b0;
    sel_mh = 1'b0;
    sel_ml = 1'b0;
    sel_stop = 1'b0;
    sel_irq = 1'b0;
    if (i_paddr[1:0] != 2'h0) begin
      sel_ctl = 1'b0;
    end else if (i_paddr[17:2] == cct_pkg::IDX_CONTROL) begin
      sel_ctl = 1'b1;
    end else if (i_paddr[17:2] == cct_pkg::IDX_STATUS) begin
      sel_sts = 1'b1;
    end else if (i_paddr[17:2] == cct_pkg::IDX_COUNT_HI) begin
      sel_ch = 1'b1;
    end else if (i_paddr[17:2] == cct_pkg::IDX_COUNT_LO) begin
      sel_cl = 1'b1;
    end else if (i_paddr[17:2] == cct_pkg::IDX_COMPARE_HI) begin
      sel_mh = 1'b1;
    end else if (i_paddr[17:2] == cct_pkg::IDX_COMPARE_LO) begin
      sel_ml = 1'b1;
    end else if (i_paddr[17:2] == cct_pkg::IDX_CLOCK_STOP) begin
      sel_stop = 1'b1;
    end else if (i_paddr[17:2] == cct_pkg::IDX_IRQ) begin
      sel_irq = 1'b1;
    end
  end

  assign hit = sel_ctl | sel_sts | sel_ch | sel_cl | sel_mh | sel_ml |
               sel_stop | sel_irq;

  always_comb begin
    sts_view = 8'h00;
    sts_view[cct_pkg::FLAG_POS[0]] = flg[0];
    sts_view[cct_pkg::FLAG_POS[1]] = flg[1];
    sts_view[cct_pkg::FLAG_POS[2]] = flg[2];
    sts_view[cct_pkg::FLAG_POS[3]] = flg[3];
    sts_view[cct_pkg::STS_OVIE_HI] = ovie_h;
    sts_view[cct_pkg::STS_CCLR_HI] = cclr_h;
    sts_view[cct_pkg::STS_OVIE_LO] = ovie_l;
    sts_view[cct_pkg::STS_CCLR_LO] = cclr_l;
  end

  // Write-only control reads as zero
  always_comb begin
    rd_mux = 8'h00;
    if (sel_sts) begin
      rd_mux = sts_view;
    end else if (sel_ch) begin
      rd_mux = cnt_h;
    end else if (sel_cl) begin
      rd_mux = mode8 ? cnt_l : temp;
    end else if (sel_mh) begin
      rd_mux = cmp_h;
    end else if (sel_ml) begin
      rd_mux = mode8 ? cmp_l : temp;
    end else if (sel_stop) begin
      rd_mux = {2'h3, clock_stop[5:0]};
    end else if (sel_irq) begin
      rd_mux = {4'h0, irq_l_en, irq_h_en, irq_l_req, irq_h_req};
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_prdata <= '0;
    end else if (setup_rd) begin
      o_prdata <= {24'h000000, rd_mux};
    end
  end

  // ==========================================================
  // Control, clock stop and staging latch
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timer_control <= cct_pkg::RST_CONTROL;
      clock_stop <= cct_pkg::RST_CLOCK_STOP;
    end else if (acc_wr & sel_ctl) begin
      timer_control <= wd;
    end else if (acc_wr & sel_stop) begin
      clock_stop <= wd;
    end
  end

  // Upper read latches lower byte, upper write parks data
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      temp <= 8'h00;
    end else if (!mode8) begin
      if (setup_rd & sel_ch) begin
        temp <= cnt_l;
      end else if (setup_rd & sel_mh) begin
        temp <= cmp_l;
      end else if (acc_wr & (sel_ch | sel_mh)) begin
        temp <= wd;
      end
    end
  end

  // ==========================================================
  // Counters and compare registers, CPU write wins
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_h <= cct_pkg::RST_COUNT;
      cnt_l <= cct_pkg::RST_COUNT;
    end else if (acc_wr & sel_cl & !mode8) begin
      cnt_h <= temp;
      cnt_l <= wd;
    end else begin
      cnt_h <= (acc_wr & sel_ch & mode8) ? wd : next_cnt_h;
      cnt_l <= (acc_wr & sel_cl) ? wd : next_cnt_l;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmp_h <= cct_pkg::RST_COMPARE;
      cmp_l <= cct_pkg::RST_COMPARE;
    end else if (acc_wr & sel_ml & !mode8) begin
      cmp_h <= temp;
      cmp_l <= wd;
    end else if (acc_wr & sel_ml) begin
      cmp_l <= wd;
    end else if (acc_wr & sel_mh & mode8) begin
      cmp_h <= wd;
    end
  end

  // ==========================================================
  // Status flags and enables
  assign flg_set = {ovf_h_evt, match_h, ovf_l_evt, match_l};

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ovie_h <= cct_pkg::RST_STATUS[cct_pkg::STS_OVIE_HI];
      cclr_h <= cct_pkg::RST_STATUS[cct_pkg::STS_CCLR_HI];
      ovie_l <= cct_pkg::RST_STATUS[cct_pkg::STS_OVIE_LO];
      cclr_l <= cct_pkg::RST_STATUS[cct_pkg::STS_CCLR_LO];
    end else if (acc_wr & sel_sts) begin
      ovie_h <= wd[cct_pkg::STS_OVIE_HI];
      cclr_h <= wd[cct_pkg::STS_CCLR_HI];
      ovie_l <= wd[cct_pkg::STS_OVIE_LO];
      cclr_l <= wd[cct_pkg::STS_CCLR_LO];
    end
  end

  // Set beats clear; clear needs a prior read of one
  for (genvar i = 0; i < 4; i++) begin : g_flag
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        flg[i] <= 1'b0;
        seen[i] <= 1'b0;
      end else if (flg_set[i]) begin
        flg[i] <= 1'b1;
        seen[i] <= seen[i] | (setup_rd & sel_sts & flg[i]);
      end else if (acc_wr & sel_sts & ~wd[cct_pkg::FLAG_POS[i]] &
                   seen[i]) begin
        flg[i] <= 1'b0;
        seen[i] <= 1'b0;
      end else if (setup_rd & sel_sts & flg[i]) begin
        seen[i] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Interrupt request and enable bits
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_h_req <= cct_pkg::RST_IRQ[cct_pkg::IRQ_REQ_HI];
      irq_l_req <= cct_pkg::RST_IRQ[cct_pkg::IRQ_REQ_LO];
      irq_h_en <= cct_pkg::RST_IRQ[cct_pkg::IRQ_EN_HI];
      irq_l_en <= cct_pkg::RST_IRQ[cct_pkg::IRQ_EN_LO];
    end else begin
      if (match_h | (ovf_h_evt & ovie_h)) begin
        irq_h_req <= 1'b1;
      end else if (acc_wr & sel_irq & ~wd[cct_pkg::IRQ_REQ_HI]) begin
        irq_h_req <= 1'b0;
      end
      if (match_l | (ovf_l_evt & ovie_l)) begin
        irq_l_req <= 1'b1;
      end else if (acc_wr & sel_irq & ~wd[cct_pkg::IRQ_REQ_LO]) begin
        irq_l_req <= 1'b0;
      end
      if (acc_wr & sel_irq) begin
        irq_h_en <= wd[cct_pkg::IRQ_EN_HI];
        irq_l_en <= wd[cct_pkg::IRQ_EN_LO];
      end
    end
  end

  assign o_upper_irq = irq_h_req & irq_h_en;
  assign o_lower_irq = irq_l_req & irq_l_en;

  // ==========================================================
  // Toggle outputs
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tog_h <= 1'b0;
      tog_l <= 1'b0;
    end else if (acc_wr & sel_ctl) begin
      tog_h <= wd[cct_pkg::CTL_TOL_HI];
      tog_l <= wd[cct_pkg::CTL_TOL_LO];
    end else begin
      if (match_h) begin
        tog_h <= ~tog_h;
      end
      if (match_l) begin
        tog_l <= ~tog_l;
      end
    end
  end

  assign o_upper_toggle_pin = tog_h;
  assign o_lower_toggle_pin = tog_l;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  cascade_carry_a: assert property (
    !mode8 && tick_l && !clr16 && cnt_l == 8'hFF && !acc_wr
    |=> cnt_h == 8'($past(cnt_h) + 8'h01) && cnt_l == 8'h00)
    else $error("upper byte missed carry");

  upper_indep_a: assert property (
    mode8 && !tick_h8 && !acc_wr |=> $stable(cnt_h))
    else $error("upper counter moved without its clock");

  pair_source_a: assert property (
    !mode8 && !tick_l && !acc_wr |=> $stable({cnt_h, cnt_l}))
    else $error("pair moved without lower clock");

  staging_a: assert property (
    !mode8 && acc_wr && sel_ch |=> temp == $past(wd) && mode8 == 1'b0)
    else $error("staging latch not loaded");

  pair_clear_a: assert property (
    clr16 && !acc_wr |=> {cnt_h, cnt_l} == 16'h0000)
    else $error("pair not cleared on match");

  ovf_flag_a: assert property (
    ovf_h_evt |=> flg[3] ##1 flg[3] || $past(acc_wr))
    else $error("upper overflow flag not set");

  ovf_req_a: assert property (
    ovf_h_evt && ovie_h |=> irq_h_req)
    else $error("overflow request not raised");

  match_req_a: assert property (
    match_h |=> flg[2] && irq_h_req)
    else $error("match flag and request not set together");

  toggle_inv_a: assert property (
    match_h && !(acc_wr && sel_ctl) |=> tog_h != $past(tog_h))
    else $error("toggle pin did not invert");

  level_write_a: assert property (
    acc_wr && sel_ctl |=> o_upper_toggle_pin == $past(wd[7]))
    else $error("toggle level write ignored");

  flag_keep_a: assert property (
    acc_wr && sel_sts && wd[7] && flg[3] |=> flg[3])
    else $error("writing one cleared a flag");

  cover_ovf_c: cover property (ovf_h_evt && !mode8);
  cover_lmatch_c: cover property (match_l ##[1:20] ovf_l_evt);
  cover_clear_c: cover property (clr16);

endmodule : cct_timer

`default_nettype wire

// ==== verif/tb_cascadable_compare_timer.sv ====
`timescale 1ns/1ns
`default_nettype none

module tb_cascadable_compare_timer;
  typedef struct packed {
    logic [32:0] lo;
    logic [32:0] hi;
  } cct_exp_s;

  // ==========================================================
  // Short names and output indices
  localparam logic [15:0] CTL = cct_pkg::IDX_CONTROL;
  localparam logic [15:0] ST = cct_pkg::IDX_STATUS;
  localparam logic [15:0] CH = cct_pkg::IDX_COUNT_HI;
  localparam logic [15:0] CL = cct_pkg::IDX_COUNT_LO;
  localparam logic [15:0] MH = cct_pkg::IDX_COMPARE_HI;
  localparam logic [15:0] ML = cct_pkg::IDX_COMPARE_LO;
  localparam logic [15:0] IRQ = cct_pkg::IDX_IRQ;
  localparam int UPIN = 3;
  localparam int LPIN = 2;
  localparam int UIRQ = 1;
  localparam int LIRQ = 0;

  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic event_pin = 1'b0;
  logic sub_clk = 1'b0;
  logic [2:0] sub_div = 3'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic up_pin;
  logic lo_pin;
  logic up_irq;
  logic lo_irq;
  logic [31:0] seed = 32'hE680;
  int num_errors = 0;
  int comparisons = 0;
  int dv [4] = '{32, 16, 4, 24};
  string nm [4] = '{"lower_irq", "upper_irq", "lower_pin", "upper_pin"};
  cct_exp_s exp_q [$];

  cct_timer DUT (
    .i_mclk(mclk),
    .i_reset_n(reset_n),
    .i_paddr(paddr),
    .i_psel(psel),
    .i_penable(penable),
    .i_pwrite(pwrite),
    .i_pwdata(pwdata),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .i_event_input_pin(event_pin),
    .i_sub_clk(sub_clk),
    .o_upper_toggle_pin(up_pin),
    .o_lower_toggle_pin(lo_pin),
    .o_upper_irq(up_irq),
    .o_lower_irq(lo_irq)
  );

  // ==========================================================
  // Clocks, subclock period six system cycles
  always #5 mclk = ~mclk;

  always @(posedge mclk) begin
    sub_div <= (sub_div == 3'h2) ? 3'h0 : sub_div + 3'h1;
    if (sub_div == 3'h2) begin
      sub_clk <= ~sub_clk;
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction : lfsr

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic xfer(input logic [15:0] idx, input logic wr,
                      input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= {idx, 2'b00};
    pwrite <= wr;
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, d);
  endtask : wr

  task automatic rd_rng(input logic [15:0] idx, input logic [32:0] lo,
                        input logic [32:0] hi);
    exp_q.push_back('{lo, hi});
    xfer(idx, 1'b0, 8'h00);
  endtask : rd_rng

  task automatic rd(input logic [15:0] idx, input logic [7:0] v);
    rd_rng(idx, {25'h0000000, v}, {25'h0000000, v});
  endtask : rd

  task automatic chk_rd(input cct_exp_s e, input logic [32:0] seen);
    comparisons++;
    if ((seen >= e.lo) !== 1'b1 || (seen <= e.hi) !== 1'b1) begin
      num_errors++;
      $display("mismatch prdata expected %h..%h seen %h", e.lo, e.hi, seen);
    end
  endtask : chk_rd

  task automatic chk_out(input int k, input logic e);
    logic [3:0] s;
    @(posedge mclk);
    s = {up_pin, lo_pin, up_irq, lo_irq};
    comparisons++;
    if (s[k] !== e) begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", nm[k], e, s[k]);
    end
  endtask : chk_out

  task automatic pulse(input int n);
    repeat (n) begin
      event_pin <= 1'b1;
      repeat (4) @(posedge mclk);
      event_pin <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
  endtask : pulse

  // ==========================================================
  // Read monitor
  always @(posedge mclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("mismatch prdata expected none seen %h", prdata);
      end else begin
        chk_rd(exp_q.pop_front(), {pslverr, prdata});
      end
    end
  end

  // ==========================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    $display("watchdog expired");
    wrap_up();
  end

  // ==========================================================
  // Tests
  initial begin
    int n;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    rd(ST, 8'h00);
    rd(CH, 8'h00);
    rd(CL, 8'h00);
    rd(MH, 8'hFF);
    rd(ML, 8'hFF);
    rd_rng(16'h0001, {1'b1, 32'h0}, {1'b1, 32'h0});
    $display("test reset_values done");

    seed = lfsr(seed);
    wr(MH, 8'h12);
    wr(ML, seed[7:0]);
    rd(MH, 8'h12);
    rd(ML, seed[7:0]);
    wr(MH, 8'h34);
    rd(MH, 8'h12);
    rd(ML, seed[7:0]);
    seed = lfsr(seed);
    wr(CH, seed[15:8] | 8'h80);
    wr(CL, seed[7:0]);
    rd(CH, seed[15:8] | 8'h80);
    rd(CL, seed[7:0]);
    $display("test pairing done");

    wr(CH, 8'hFF);
    wr(CL, 8'hFE);
    wr(ST, 8'h20);
    wr(IRQ, 8'h04);
    pulse(2);
    rd(ST, 8'hA0);
    chk_out(UIRQ, 1'b1);
    rd(CH, 8'h00);
    rd(CL, 8'h00);
    wr(ST, 8'hA0);
    rd(ST, 8'hA0);
    wr(ST, 8'h20);
    rd(ST, 8'h20);
    wr(IRQ, 8'h04);
    chk_out(UIRQ, 1'b0);
    $display("test overflow16 done");

    wr(ST, 8'h10);
    wr(CTL, 8'h80);
    chk_out(UPIN, 1'b1);
    rd(CTL, 8'h00);
    wr(MH, 8'h00);
    wr(ML, 8'h03);
    wr(CH, 8'h00);
    wr(CL, 8'h00);
    pulse(4);
    chk_out(UPIN, 1'b0);
    chk_out(LPIN, 1'b0);
    rd(CH, 8'h00);
    rd(CL, 8'h00);
    rd(ST, 8'h50);
    chk_out(UIRQ, 1'b1);
    wr(ST, 8'h00);
    $display("test match16 done");

    for (int c = 4; c < 8; c++) begin
      wr(CTL, {1'b0, 3'(c), 1'b0, 3'(c)});
      wr(MH, 8'hFF);
      wr(ML, 8'hFF);
      wr(CH, 8'h00);
      wr(CL, 8'h00);
      repeat (480) @(posedge mclk);
      n = 484 / dv[c - 4];
      rd_rng(CH, {25'h0, 8'(n - 2)}, {25'h0, 8'(n + 2)});
      rd_rng(CL, {25'h0, 8'(n - 2)}, {25'h0, 8'(n + 2)});
    end
    $display("test clock_selects done");

    wr(CTL, 8'h68);
    chk_out(LPIN, 1'b1);
    wr(ST, 8'h03);
    wr(MH, 8'hFF);
    wr(ML, 8'h02);
    wr(CH, 8'h00);
    wr(CL, 8'h00);
    wr(IRQ, 8'h04);
    pulse(3);
    chk_out(LPIN, 1'b0);
    rd(CL, 8'h00);
    repeat (1200) @(posedge mclk);
    rd(ST, 8'hC7);
    chk_out(UPIN, 1'b1);
    chk_out(UIRQ, 1'b1);
    chk_out(LIRQ, 1'b0);
    wr(IRQ, 8'h0F);
    chk_out(LIRQ, 1'b1);
    $display("test mode8 done");

    repeat (2) @(posedge mclk);
    wrap_up();
  end
endmodule : tb_cascadable_compare_timer

`default_nettype wire
